/* File: start_interlock_defines.vh */
// constants for the test start and abort interlock block
`ifndef START_INTERLOCK_DEFINES_VH
`define START_INTERLOCK_DEFINES_VH

// ****************************************************
// register word addresses
// ****************************************************
`define REG_CTRL        4'h0
`define REG_COUPLE      4'h1
`define REG_STATUS      4'h2
`define REG_EVENT       4'h3
`define REG_MASK        4'h4

// ****************************************************
// control register fields
// ****************************************************
`define CTRL_REMOTE_BIT 0
`define CTRL_POL_LSB    1
`define CTRL_POL_MSB    2
`define CTRL_MENU_BIT   3
`define CTRL_GRAPH_BIT  4
`define CTRL_DONE_BIT   5
`define CTRL_RST        8'h00

// ****************************************************
// remote start policies
// ****************************************************
`define POL_LID         2'h0
`define POL_PERMIT      2'h1
`define POL_TWOHAND     2'h2

// ****************************************************
// event bits
// ****************************************************
`define EV_START        0
`define EV_ABORT        1
`define EV_USER_ABORT   2
`define EV_DONE         3

// ****************************************************
// timing
// ****************************************************
`define DEBOUNCE_US     10
`define CLK_MHZ         10
`define DEBOUNCE_CYC    (`DEBOUNCE_US * `CLK_MHZ)
`define COUPLE_RST      16'h0064

`endif

/* File: test_start_interlock.v */
// test cycle start and abort interlock with wishbone registers
//
// Overview of operation
// - only local or only remote source used
// - green starts, red aborts in local
// - remote start, permit, abort inputs monitored
// - remote abort ends cycle in every policy
// - three remote start policies selectable
// - lid policy: start release aborts cycle
// - lid and two-hand ignore permit input
// - permit policy: start needs permit first
// - permit policy: permit drop aborts cycle
// - two-hand: start held through coupling time
// - two-hand: early start release aborts
// - no start while a menu shows
// - graph view still accepts starts
// - stop always honoured, never masked
// - stop abort records operator abort result
// - coupling phase opens outputs for period
`timescale 1ns/1ps
`include "start_interlock_defines.vh"

module test_start_interlock (
   // clock, reset, enable
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        ce_i,
   // wishbone slave
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [3:0]  adr_i,
   input  wire [0:0]  sel_i,
   input  wire [15:0] dat_i,
   output reg  [15:0] dat_o,
   output reg         ack_o,
   // closures
   input  wire        green_btn_i,
   input  wire        red_btn_i,
   input  wire        remote_start_i,
   input  wire        remote_permit_i,
   input  wire        remote_abort_i,
   // cycle outputs
   output reg         couple_o,
   output reg         cycle_run_o,
   output reg         operator_abort_result_o,
   output wire        irq_o
);

   // ****************************************************
   // input conditioning
   // ****************************************************
   localparam NIN = 5;
   localparam [6:0] DB_MAX = `DEBOUNCE_CYC;
   wire [NIN-1:0] raw_w = {remote_abort_i, remote_permit_i, remote_start_i,
                           red_btn_i, green_btn_i};
   wire [NIN-1:0] clean_w;

   genvar g;
   generate
      for (g = 0; g < NIN; g = g + 1) begin : cond
         reg       s1_r;
         reg       s2_r;
         reg       st_r;
         reg [6:0] cnt_r;
         // two-stage sync then stable-count filter
         always @(posedge clk_i) begin
            if (rst_i) begin
               s1_r  <= 1'b0;
               s2_r  <= 1'b0;
               st_r  <= 1'b0;
               cnt_r <= 7'h00;
            end else if (ce_i) begin
               s1_r <= raw_w[g];
               s2_r <= s1_r;
               if (s2_r == st_r) begin
                  cnt_r <= 7'h00;
               end else if (cnt_r == DB_MAX - 7'h01) begin
                  st_r  <= s2_r;
                  cnt_r <= 7'h00;
               end else begin
                  cnt_r <= cnt_r + 7'h01;
               end
            end
         end
         assign clean_w[g] = st_r;
      end
   endgenerate

   wire green_w  = clean_w[0];
   wire red_w    = clean_w[1];
   wire rstart_w = clean_w[2];
   wire permit_w = clean_w[3];
   wire rabort_w = clean_w[4];

   // ****************************************************
   // registers
   // ****************************************************
   reg  [7:0]  ctrl_r;
   reg  [15:0] couple_time_r;
   reg  [3:0]  event_r;
   reg  [3:0]  mask_r;
   reg  [3:0]  ev_set;
   wire        remote_w = ctrl_r[`CTRL_REMOTE_BIT];
   wire [1:0]  pol_w    = ctrl_r[`CTRL_POL_MSB:`CTRL_POL_LSB];
   wire        menu_w   = ctrl_r[`CTRL_MENU_BIT];
   wire        graph_w  = ctrl_r[`CTRL_GRAPH_BIT];

   // address decode shared by read and write paths
   function is_reg;
      input [3:0] a;
      input [3:0] r;
      begin
         is_reg = (a == r);
      end
   endfunction

   wire req_w = cyc_i & stb_i & ~ack_o;
   wire wr_w  = req_w & we_i & sel_i[0];
   wire rd_ev = req_w & ~we_i & is_reg(adr_i, `REG_EVENT);

   // ****************************************************
   // cycle state machine
   // ****************************************************
   localparam [1:0] S_IDLE   = 2'h0;
   localparam [1:0] S_COUPLE = 2'h1;
   localparam [1:0] S_RUN    = 2'h2;

   reg  [1:0]  state_r;
   reg  [1:0]  state_nxt;
   reg  [15:0] ctime_r;
   reg         green_d_r;
   reg         rstart_d_r;
   reg         done_req_r;

   wire green_rise  = green_w & ~green_d_r;
   wire rstart_rise = rstart_w & ~rstart_d_r;
   // starts are blocked in menus except graph views
   wire start_ok    = ~menu_w | graph_w;
   // source selection: other source fully ignored
   wire start_req   = remote_w ?
                      (rstart_rise & ((pol_w != `POL_PERMIT) | permit_w))
                      : green_rise;
   // stop requests bypass every lockout
   wire user_stop   = remote_w ? rabort_w : red_w;
   // policy-specific hold conditions
   reg  hold_lost;
   always @* begin
      case (pol_w)
         `POL_LID:     hold_lost = ~rstart_w;
         `POL_PERMIT:  hold_lost = ~permit_w;
         `POL_TWOHAND: hold_lost = ~rstart_w & (state_r == S_COUPLE);
         default:      hold_lost = 1'b0;
      endcase
   end
   wire abort_w = (state_r != S_IDLE) & (user_stop | (remote_w & hold_lost));

   // next state
   always @* begin
      state_nxt = state_r;
      ev_set    = 4'h0;
      case (state_r)
         S_IDLE: begin
            if (start_req & start_ok & ~user_stop) begin
               state_nxt         = S_COUPLE;
               ev_set[`EV_START] = 1'b1;
            end
         end
         S_COUPLE: begin
            if (abort_w) begin
               state_nxt = S_IDLE;
            end else if (ctime_r == 16'h0000) begin
               state_nxt = S_RUN;
            end
         end
         S_RUN: begin
            if (abort_w) begin
               state_nxt = S_IDLE;
            end else if (done_req_r) begin
               state_nxt        = S_IDLE;
               ev_set[`EV_DONE] = 1'b1;
            end
         end
         default: state_nxt = S_IDLE;
      endcase
      if (abort_w) begin
         ev_set[`EV_ABORT] = 1'b1;
         ev_set[`EV_USER_ABORT] = user_stop;
      end
   end

   // state, coupling timer and outputs
   always @(posedge clk_i) begin
      if (rst_i) begin
         state_r                 <= S_IDLE;
         ctime_r                 <= 16'h0000;
         green_d_r               <= 1'b0;
         rstart_d_r              <= 1'b0;
         couple_o                <= 1'b0;
         cycle_run_o             <= 1'b0;
         operator_abort_result_o <= 1'b0;
      end else if (ce_i) begin
         state_r    <= state_nxt;
         green_d_r  <= green_w;
         rstart_d_r <= rstart_w;
         if (state_r == S_IDLE) begin
            ctime_r <= couple_time_r;
         end else if (ctime_r != 16'h0000) begin
            ctime_r <= ctime_r - 16'h0001;
         end
         couple_o    <= (state_nxt == S_COUPLE);
         cycle_run_o <= (state_nxt != S_IDLE);
         if (ev_set[`EV_START]) begin
            operator_abort_result_o <= 1'b0;
         end else if (ev_set[`EV_USER_ABORT]) begin
            operator_abort_result_o <= 1'b1;
         end
      end
   end

   // ****************************************************
   // wishbone slave and event registers
   // ****************************************************
   always @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r        <= `CTRL_RST;
         couple_time_r <= `COUPLE_RST;
         event_r       <= 4'h0;
         mask_r        <= 4'h0;
         done_req_r    <= 1'b0;
         ack_o         <= 1'b0;
         dat_o         <= 16'h0000;
      end else if (ce_i) begin
         ack_o      <= req_w;
         done_req_r <= 1'b0;
         // set beats the read clear
         event_r    <= (rd_ev ? 4'h0 : event_r) | ev_set;
         if (wr_w) begin
            if (is_reg(adr_i, `REG_CTRL)) begin
               ctrl_r     <= {3'h0, dat_i[4:0]};
               done_req_r <= dat_i[`CTRL_DONE_BIT];
            end
            if (is_reg(adr_i, `REG_COUPLE)) begin
               couple_time_r <= dat_i;
            end
            if (is_reg(adr_i, `REG_MASK)) begin
               mask_r <= dat_i[3:0];
            end
         end
         if (req_w & ~we_i) begin
            case (adr_i)
               `REG_CTRL:   dat_o <= {8'h00, ctrl_r};
               `REG_COUPLE: dat_o <= couple_time_r;
               `REG_STATUS: dat_o <= {12'h000, operator_abort_result_o,
                                      couple_o, state_r};
               `REG_EVENT:  dat_o <= {12'h000, event_r};
               `REG_MASK:   dat_o <= {12'h000, mask_r};
               default:     dat_o <= 16'h0000;
            endcase
         end
      end
   end

   assign irq_o = |(event_r & mask_r);

endmodule

/* File: start_interlock_props.sv */
// checker for the start interlock ports
`timescale 1ns/1ps
module start_interlock_props (
   // clock, reset, bus
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   input wire cyc_i,
   input wire stb_i,
   input wire ack_o,
   // closures and cycle outputs
   input wire green_btn_i,
   input wire remote_start_i,
   input wire couple_o,
   input wire cycle_run_o,
   input wire operator_abort_result_o,
   input wire irq_o
);
   // ********
   // properties
   // ********
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_take; cyc_i && stb_i && !ack_o && ce_i; endsequence
   sequence s_pulse; ack_o ##1 !ack_o; endsequence
   property p_bus_ack; s_take |=> s_pulse; endproperty
   property p_couple_run; couple_o |-> cycle_run_o; endproperty
   property p_couple_first; $rose(cycle_run_o) |-> couple_o; endproperty
   property p_run_cause;
      $rose(cycle_run_o) |-> $past(green_btn_i, 50) || $past(remote_start_i, 50);
   endproperty
   property p_stop_flag;
      $rose(operator_abort_result_o) |-> !cycle_run_o && $past(cycle_run_o, 2);
   endproperty
   property p_flag_hold; $rose(operator_abort_result_o) |=> operator_abort_result_o [*4];
   endproperty
   property p_flag_clear; $rose(cycle_run_o) |-> ##1 !operator_abort_result_o; endproperty
   property p_reset_quiet; $fell(rst_i) |-> !(cycle_run_o || couple_o || ack_o || irq_o);
   endproperty
   a_bus_ack: assert property (p_bus_ack) else $error("ack not single");
   a_couple_run: assert property (p_couple_run) else $error("couple idle");
   a_couple_first: assert property (p_couple_first) else $error("no couple");
   a_run_cause: assert property (p_run_cause) else $error("start no pin");
   a_stop_flag: assert property (p_stop_flag) else $error("flag no abort");
   a_flag_hold: assert property (p_flag_hold) else $error("flag short");
   a_flag_clear: assert property (p_flag_clear) else $error("flag kept");
   a_reset_quiet: assert property (p_reset_quiet) else $error("busy reset");
endmodule
bind test_start_interlock start_interlock_props start_interlock_props_i (.clk_i, .rst_i,
   .ce_i, .cyc_i, .stb_i, .ack_o, .green_btn_i, .remote_start_i, .couple_o, .cycle_run_o,
   .operator_abort_result_o, .irq_o);

/* File: panel_model.sv */
// buttons, fixture interlock and safety device closures
`timescale 1ns/1ps
module panel_model (
   // clock and requested levels
   input  wire       clk_i,
   input  wire [4:0] want_i,
   // contacts, open reads low
   output reg  [4:0] pins_o
);
   // ********
   // contacts
   // ********
   // a requested closure stays made until released
   initial pins_o = 5'h00;
   always @(posedge clk_i) begin
      pins_o <= want_i;
   end
endmodule

/* File: test_start_interlock_tb.sv */
// self-checking bench for the start interlock
`timescale 1ns/1ps
module test_start_interlock_tb;
   // ********
   // signals
   // ********
   reg          clk_i = 1'b0;
   reg          rst_i = 1'b1;
   reg          cyc_i = 1'b0;
   reg          stb_i = 1'b0;
   reg          we_i = 1'b0;
   reg  [3:0]   adr_i = 4'h0;
   reg  [15:0]  dat_i = 16'h0000;
   reg  [4:0]   want = 5'h00;
   reg  [15:0]  rd;
   wire [15:0]  dat_o;
   wire [4:0]   pins;
   wire         ack_o, couple_o, cycle_run_o, res_o, irq_o;
   integer      miscompares = 0;
   integer      samples_checked = 0;
   integer      i, n;
   // rows: control bits, closures, expected run
   logic [10:0] tv [11] = '{11'h003, 11'h042, 11'h008, 11'h049, 11'h0c8, 11'h0d9,
                            11'h149, 11'h202, 11'h603, 11'h068, 11'h059};
   always #50 clk_i = ~clk_i;
   test_start_interlock test_start_interlock_i (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(1'b1), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .green_btn_i(pins[0]), .red_btn_i(pins[1]),
      .remote_start_i(pins[2]), .remote_permit_i(pins[3]), .remote_abort_i(pins[4]),
      .couple_o(couple_o), .cycle_run_o(cycle_run_o),
      .operator_abort_result_o(res_o), .irq_o(irq_o));
   panel_model panel_model_i (.clk_i(clk_i), .want_i(want), .pins_o(pins));
   // compare and count
   task chk(input [15:0] seen, input [15:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("mismatch at %0t: %h not %h", $time, seen, exp);
         end
      end
   endtask
   // one classic bus cycle, request held until ack is sampled high
   task wb(input w, input [3:0] a, input [15:0] d);
      begin
         @(posedge clk_i);
         cyc_i <= 1'b1;
         stb_i <= 1'b1;
         we_i <= w;
         adr_i <= a;
         dat_i <= d;
         n = 0;
         do begin
            @(posedge clk_i);
            n = n + 1;
         end while (ack_o !== 1'b1);
         rd = dat_o;
         cyc_i <= 1'b0;
         stb_i <= 1'b0;
      end
   endtask
   // set closures, then wait t cycles
   task pin(input [4:0] v, input integer t);
      begin
         @(posedge clk_i);
         want <= v;
         repeat (t) @(negedge clk_i);
      end
   endtask
   task rst_dut;
      begin
         @(posedge clk_i);
         rst_i <= 1'b1;
         want <= 5'h00;
         repeat (3) @(posedge clk_i);
         rst_i <= 1'b0;
      end
   endtask
   task final_report;
      begin
         $display("checks %0d mismatches %0d", samples_checked, miscompares);
         if (miscompares == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
         end else begin
            $display("== FAILED ==");
         end
         $finish;
      end
   endtask
   // ********
   // tests
   // ********
   initial begin
      for (i = 0; i < 11; i = i + 1) begin
         rst_dut;
         wb(1'b1, 4'h0, {11'h000, tv[i][10:6]});
         pin(tv[i][5:1], 130);
         chk(cycle_run_o, tv[i][0]);
         $display("row %0d done", i);
      end
      // reset values, unmapped index
      rst_dut;
      wb(1'b0, 4'h1, 16'h0000);
      chk(rd, 16'h0064);
      wb(1'b0, 4'hf, 16'h0000);
      chk({rd[11:0], irq_o, couple_o, cycle_run_o, res_o}, 16'h0000);
      // lid release aborts, interrupt raised, masked, events read
      wb(1'b1, 4'h4, 16'h0002);
      wb(1'b1, 4'h0, 16'h0001);
      pin(5'h04, 130);
      chk(couple_o, 1'b1);
      pin(5'h00, 130);
      chk({cycle_run_o, irq_o}, 2'h1);
      wb(1'b1, 4'h4, 16'h0000);
      chk(irq_o, 1'b0);
      wb(1'b0, 4'h3, 16'h0000);
      chk(rd, 16'h0003);
      $display("lid test done");
      // permit drop aborts
      wb(1'b1, 4'h0, 16'h0003);
      pin(5'h0c, 130);
      pin(5'h04, 130);
      chk(cycle_run_o, 1'b0);
      // two-hand: early release aborts, late release ignored
      rst_dut;
      wb(1'b1, 4'h1, 16'h0190);
      wb(1'b1, 4'h0, 16'h0005);
      pin(5'h04, 130);
      pin(5'h00, 130);
      chk(cycle_run_o, 1'b0);
      pin(5'h04, 600);
      pin(5'h00, 130);
      chk({couple_o, cycle_run_o}, 2'h1);
      wb(1'b1, 4'h0, 16'h0025);
      wb(1'b0, 4'h3, 16'h0000);
      chk({rd[14:0], cycle_run_o}, 16'h0016);
      $display("two-hand test done");
      // stop in a menu screen, then a short glitch
      wb(1'b1, 4'h0, 16'h0000);
      pin(5'h01, 130);
      wb(1'b1, 4'h0, 16'h0008);
      pin(5'h02, 130);
      chk({cycle_run_o, res_o}, 2'h1);
      wb(1'b0, 4'h2, 16'h0000);
      chk(rd, 16'h0008);
      wb(1'b1, 4'h0, 16'h0001);
      pin(5'h04, 20);
      pin(5'h00, 130);
      chk(cycle_run_o, 1'b0);
      $display("stop test done");
      final_report;
   end
   // hang guard
   initial begin
      repeat (30000) @(posedge clk_i);
      miscompares = miscompares + 1;
      final_report;
   end
endmodule
